// >>> shared/cfsr_pkg.sv
package cfsr_pkg;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned PC_W = 13;
  localparam int unsigned STACK_DEPTH = 8;
  localparam int unsigned SP_W = 3;

  // Register addresses on the register port.
  localparam logic [8:0] ADDR_INDIRECT = 9'h000;
  localparam logic [8:0] ADDR_PCL = 9'h002;
  localparam logic [8:0] ADDR_STATUS = 9'h003;
  localparam logic [8:0] ADDR_POINTER = 9'h004;
  localparam logic [8:0] ADDR_FLAGS = 9'h00C;
  localparam logic [8:0] ADDR_LATCH = 9'h00A;
  localparam logic [8:0] ADDR_CAUSE = 9'h08E;
  localparam logic [8:0] ADDR_TRIM = 9'h090;
  localparam logic [6:0] BANK_MASK = 7'h7F;

  // Field positions.
  localparam int unsigned FLAG_NVM = 7;
  localparam int unsigned FLAG_ADC = 6;
  localparam int unsigned FLAG_CMP = 3;
  localparam int unsigned FLAG_TMR1 = 0;
  localparam int unsigned CAUSE_POR = 1;
  localparam int unsigned CAUSE_BOD = 0;
  localparam int unsigned STATUS_BANK = 7;

  localparam logic [7:0] FLAGS_MASK = 8'hC9;
  localparam logic [7:0] CAUSE_MASK = 8'h03;
  localparam logic [7:0] TRIM_MASK = 8'hFC;
  localparam logic [7:0] LATCH_MASK = 8'h1F;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] TRIM_RST = 8'h80;
  localparam logic [PC_W-1:0] PC_RST = 13'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    CFSR_OP_NONE = 3'h0,
    CFSR_OP_STEP = 3'h1,
    CFSR_OP_JUMP = 3'h3,
    CFSR_OP_CALL = 3'h2,
    CFSR_OP_IRQ = 3'h6,
    CFSR_OP_RET = 3'h7
  } cfsr_op_t;

  typedef struct packed {
    cfsr_op_t op;
    logic [10:0] target;
  } cfsr_flow_t;

  typedef struct packed {
    logic nvm_done;
    logic adc_done;
    logic cmp_change;
    logic tmr1_ovf;
  } cfsr_events_t;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cfsr_bus_t;
endpackage : cfsr_pkg

// >>> rtl/cfsr_core.sv
// Operation
// - Peripheral flags set on their event regardless of any enable bit.
// - Nonvolatile write done sets bit 7; holds until software clears it.
// - Conversion done sets bit 6; holds until software clears it.
// - Comparator change sets bit 3; only a software write clears it.
// - Timer one overflow sets bit 0; holds until software clears it.
// - Power-on reset reads 0 at bit 1; software then writes 1.
// - Brown-out drives bit 0 to 0; software writes it back to 1.
// - Six-bit oscillator trim code in bits 7..2; bits 1..0 read 0.
// - Program counter 13 bits; low byte accessible, upper bits hidden.
// - Every reset clears the whole program counter; here only rstn_i does, por_i and bod_i leave it unchanged.
// - Writing the low byte loads upper bits from latch bits 4..0.
// - Call or jump takes top two bits from latch bits 4..3.
// - Eight-entry 13-bit return stack, pointer invisible to software.
// - Push on call or interrupt; pop on return.
// - Push and pop leave the upper-address latch unchanged.
// - Stack wraps circularly; ninth push overwrites the first.
// - No stack overflow or underflow indication exists.
// - Indirect register accesses the location chosen by the pointer.
// - Indirect self-access reads 00h and writes store nothing.
// - Indirect address is bank bit above the 8-bit pointer.
//
// The implementer's own choice: the address-and-strobe port.
module cfsr_core
  import cfsr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic por_i,
  input wire logic bod_i,
  input wire cfsr_bus_t bus_i,
  input wire cfsr_flow_t flow_i,
  input wire cfsr_events_t evt_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [7:0] rdata_o,
  output logic [PC_W-1:0] pc_o,
  output logic [5:0] trim_code_o,
  output logic [7:0] peripheral_irq_flags_o,
  output logic [ADDR_W-1:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_wr_o,
  output logic mem_rd_o
);

  // Reset-cause inputs come from the supply monitor, outside this clock.
  // Only the second stage of each pair is read, so a metastable first stage never reaches logic.
  logic por_s1_q;
  logic por_s2_q;
  logic bod_s1_q;
  logic bod_s2_q;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      por_s1_q <= 1'b0;
      por_s2_q <= 1'b0;
      bod_s1_q <= 1'b0;
      bod_s2_q <= 1'b0;
    end else begin
      por_s1_q <= por_i;
      por_s2_q <= por_s1_q;
      bod_s1_q <= bod_i;
      bod_s2_q <= bod_s1_q;
    end
  end


  // Architectural registers, one flop group per concern.
  logic [7:0] pcl_q;
  logic [7:0] latch_q;
  logic [7:0] pointer_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] trim_q;
  logic [1:0] cause_q;
  logic [1:0] cause_d;
  logic bank_q;
  logic [12:8] pch_q;
  logic [PC_W-1:0] stack_q [STACK_DEPTH];
  logic [SP_W-1:0] sp_q;


  logic [PC_W-1:0] pc_now;
  logic [PC_W-1:0] pc_next_seq;
  assign pc_now = {pch_q, pcl_q};
  assign pc_next_seq = pc_now + 13'h0001;

  // Decode folds both banks onto one map; only bank bit matters for three regs (flags, cause, trim).
  logic [ADDR_W-1:0] ind_addr;
  logic is_ind;
  logic wr_ind_self;
  assign ind_addr = {bank_q, pointer_q};
  assign is_ind = (bus_i.addr[6:0] & BANK_MASK) == ADDR_INDIRECT[6:0];
  assign wr_ind_self = (ind_addr[6:0] == ADDR_INDIRECT[6:0]);

  logic [ADDR_W-1:0] eff_addr;
  logic [7:0] eff_wdata;
  assign eff_addr = is_ind ? ind_addr : bus_i.addr;
  assign eff_wdata = bus_i.wdata;


  // A pointer that selects the indirect register itself turns the access into a no-op.
  logic eff_wr;
  logic eff_rd;
  assign eff_wr = bus_i.wr && !(is_ind && wr_ind_self);
  assign eff_rd = bus_i.rd && !(is_ind && wr_ind_self);


  logic w_flags;
  logic w_cause;
  logic w_trim;
  logic w_latch;
  logic w_ptr;
  logic w_status;
  logic w_pcl;
  assign w_flags = eff_wr && eff_addr == ADDR_FLAGS;
  assign w_cause = eff_wr && eff_addr == ADDR_CAUSE;
  assign w_trim = eff_wr && eff_addr == ADDR_TRIM;
  assign w_latch = eff_wr && eff_addr[6:0] == ADDR_LATCH[6:0];
  assign w_ptr = eff_wr && eff_addr[6:0] == ADDR_POINTER[6:0];
  assign w_status = eff_wr && eff_addr[6:0] == ADDR_STATUS[6:0];
  assign w_pcl = eff_wr && eff_addr[6:0] == ADDR_PCL[6:0];

  // Flags: set beats a same-cycle software clear so no event is lost.
  logic [7:0] evt_vec;
  always_comb begin
    evt_vec = 8'h00;
    evt_vec[FLAG_NVM] = evt_i.nvm_done;
    evt_vec[FLAG_ADC] = evt_i.adc_done;
    evt_vec[FLAG_CMP] = evt_i.cmp_change;
    evt_vec[FLAG_TMR1] = evt_i.tmr1_ovf;
  end


  always_comb begin
    flags_d = flags_q | evt_vec;
    if (w_flags) begin
      flags_d = eff_wdata | evt_vec;
    end
    flags_d = flags_d & FLAGS_MASK;
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Cause bits: hardware events force 0 and win over a software write of 1.
  always_comb begin
    cause_d = cause_q;
    if (w_cause) begin
      cause_d[CAUSE_POR] = eff_wdata[CAUSE_POR];
      cause_d[CAUSE_BOD] = eff_wdata[CAUSE_BOD];
    end
    if (por_s2_q) begin
      cause_d[CAUSE_POR] = 1'b0;
    end
    if (bod_s2_q) begin
      cause_d[CAUSE_BOD] = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cause_q <= 2'h0;
    end else begin
      cause_q <= cause_d;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      trim_q <= TRIM_RST;
    end else if (w_trim) begin
      trim_q <= eff_wdata & TRIM_MASK;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      latch_q <= ZERO_BYTE;
    end else if (w_latch) begin
      latch_q <= eff_wdata & LATCH_MASK;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pointer_q <= ZERO_BYTE;
      bank_q <= 1'b0;
    end else begin
      if (w_ptr) begin
        pointer_q <= eff_wdata;
      end
      if (w_status) begin
        bank_q <= eff_wdata[STATUS_BANK];
      end
    end
  end

  // Program counter; a low-byte write takes priority over flow control.
  logic [PC_W-1:0] jump_pc;
  logic [PC_W-1:0] stack_top;
  logic [PC_W-1:0] pc_d;
  assign jump_pc = {latch_q[4:3], flow_i.target};
  assign stack_top = stack_q[sp_q - 3'h1];

  always_comb begin
    pc_d = pc_now;
    if (w_pcl) begin
      pc_d = {latch_q[4:0], eff_wdata};
    end else begin
      unique case (flow_i.op)
        CFSR_OP_NONE: begin
          pc_d = pc_now;
        end
        CFSR_OP_STEP: begin
          pc_d = pc_next_seq;
        end
        CFSR_OP_JUMP, CFSR_OP_CALL, CFSR_OP_IRQ: begin
          pc_d = jump_pc;
        end
        CFSR_OP_RET: begin
          pc_d = stack_top;
        end
        default: begin
          pc_d = pc_now;
        end
      endcase
    end
  end

  // Only rstn_i lands here; por_i and bod_i change cause bits alone, so fetching restarts at address zero on rstn_i only.
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pcl_q <= PC_RST[7:0];
      pch_q <= PC_RST[12:8];
    end else begin
      pcl_q <= pc_d[7:0];
      pch_q <= pc_d[12:8];
    end
  end

  // Stack pointer wraps silently; no overflow or underflow status exists.
  // Software that nests deeper than eight calls loses its oldest return address.
  logic push;
  logic pop;
  logic [SP_W-1:0] sp_d;
  assign push = !w_pcl && (flow_i.op == CFSR_OP_CALL || flow_i.op == CFSR_OP_IRQ);
  assign pop = !w_pcl && flow_i.op == CFSR_OP_RET;

  always_comb begin
    sp_d = sp_q;
    if (push) begin
      sp_d = sp_q + 3'h1;
    end else if (pop) begin
      sp_d = sp_q - 3'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sp_q <= 3'h0;
    end else begin
      sp_q <= sp_d;
    end
  end

  generate
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
      always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          stack_q[i] <= PC_RST;
        end else if (push && sp_q == SP_W'(i)) begin
          stack_q[i] <= pc_next_seq;
        end
      end
    end
  endgenerate

  // Read data one cycle after the strobe; outside data goes through memory.
  logic local_hit;
  logic [7:0] rd_d;
  always_comb begin
    local_hit = 1'b1;
    rd_d = ZERO_BYTE;
    if (bus_i.rd && is_ind && wr_ind_self) begin
      rd_d = ZERO_BYTE;
    end else if (eff_addr == ADDR_FLAGS) begin
      rd_d = flags_q;
    end else if (eff_addr == ADDR_CAUSE) begin
      rd_d = {6'h00, cause_q};
    end else if (eff_addr == ADDR_TRIM) begin
      rd_d = trim_q;
    end else if (eff_addr[6:0] == ADDR_PCL[6:0]) begin
      rd_d = pcl_q;
    end else if (eff_addr[6:0] == ADDR_LATCH[6:0]) begin
      rd_d = latch_q;
    end else if (eff_addr[6:0] == ADDR_POINTER[6:0]) begin
      rd_d = pointer_q;
    end else if (eff_addr[6:0] == ADDR_STATUS[6:0]) begin
      rd_d = {bank_q, 7'h00};
    end else begin
      local_hit = 1'b0;
    end
  end

  logic fwd_q;
  logic [7:0] rd_q;
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_q <= ZERO_BYTE;
      fwd_q <= 1'b0;
    end else begin
      rd_q <= bus_i.rd ? rd_d : ZERO_BYTE;
      fwd_q <= eff_rd && !local_hit;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mem_addr_o <= '0;
      mem_wdata_o <= ZERO_BYTE;
      mem_wr_o <= 1'b0;
      mem_rd_o <= 1'b0;
    end else begin
      mem_addr_o <= eff_addr;
      mem_wdata_o <= eff_wdata;
      mem_wr_o <= eff_wr && !local_hit;
      mem_rd_o <= eff_rd && !local_hit;
    end
  end

  // Memory answers in the cycle its strobe is out, so mux it in combinationally.
  assign rdata_o = fwd_q ? mem_rdata_i : rd_q;
  assign pc_o = pc_now;
  assign trim_code_o = trim_q[7:2];
  assign peripheral_irq_flags_o = flags_q;

endmodule : cfsr_core

// >>> bench/cfsr_core_sva.sv
module cfsr_core_sva
  import cfsr_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic por_i,
  input wire logic bod_i,
  input wire cfsr_bus_t bus_i,
  input wire cfsr_flow_t flow_i,
  input wire cfsr_events_t evt_i,
  input wire logic [7:0] mem_rdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic [PC_W-1:0] pc_o,
  input wire logic [5:0] trim_code_o,
  input wire logic [7:0] peripheral_irq_flags_o,
  input wire logic [ADDR_W-1:0] mem_addr_o,
  input wire logic [7:0] mem_wdata_o,
  input wire logic mem_wr_o,
  input wire logic mem_rd_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);
  wire pcl_wr = bus_i.wr && bus_i.addr[6:0] == ADDR_PCL[6:0];
  wire flag_wr = bus_i.wr && bus_i.addr == ADDR_FLAGS;
  wire [7:0] flg = peripheral_irq_flags_o;
  a_nvm_sets: assert property (evt_i.nvm_done |=> flg[FLAG_NVM])
    else $error("write done flag not set");
  a_adc_sets: assert property (evt_i.adc_done |=> flg[FLAG_ADC])
    else $error("conversion flag not set");
  a_cmp_sets: assert property (evt_i.cmp_change |=> flg[FLAG_CMP])
    else $error("comparator flag not set");
  a_tmr_sets: assert property (evt_i.tmr1_ovf |=> flg[FLAG_TMR1])
    else $error("timer flag not set");
  a_flags_sticky: assert property (!flag_wr |=> (flg & $past(flg)) == $past(flg))
    else $error("flag dropped without a write");
  a_flags_unused: assert property ((flg & ~FLAGS_MASK) == 8'h00)
    else $error("unused flag bit set");
  a_trim_load: assert property (bus_i.wr && bus_i.addr == ADDR_TRIM
    |=> trim_code_o == $past(bus_i.wdata[7:2])) else $error("trim code not loaded");
  a_call_target: assert property (flow_i.op == CFSR_OP_CALL && !pcl_wr
    |=> pc_o[10:0] == $past(flow_i.target)) else $error("call target wrong");
  a_step_incr: assert property (flow_i.op == CFSR_OP_STEP && !pcl_wr
    |=> pc_o == $past(pc_o) + 13'h1) else $error("step did not advance");
  sequence call_then_ret;
    flow_i.op == CFSR_OP_CALL && !pcl_wr ##1 flow_i.op == CFSR_OP_NONE && !pcl_wr
      ##1 flow_i.op == CFSR_OP_RET && !pcl_wr;
  endsequence
  a_call_return: assert property (call_then_ret |=> pc_o == $past(pc_o, 3) + 13'h1)
    else $error("return address wrong");
  c_call: cover property (flow_i.op == CFSR_OP_CALL);
  c_ret: cover property (flow_i.op == CFSR_OP_RET);
  c_mem_wr: cover property (mem_wr_o);
endmodule : cfsr_core_sva

bind cfsr_core cfsr_core_sva u_sva (.mclk_i(mclk_i), .rstn_i(rstn_i), .por_i(por_i),
  .bod_i(bod_i), .bus_i(bus_i), .flow_i(flow_i), .evt_i(evt_i), .mem_rdata_i(mem_rdata_i),
  .rdata_o(rdata_o), .pc_o(pc_o), .trim_code_o(trim_code_o),
  .peripheral_irq_flags_o(peripheral_irq_flags_o), .mem_addr_o(mem_addr_o),
  .mem_wdata_o(mem_wdata_o), .mem_wr_o(mem_wr_o), .mem_rd_o(mem_rd_o));

// >>> bench/cfsr_core_bench.sv
module cfsr_core_bench;
  import cfsr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 0, rstn_i = 0, por_i = 0, bod_i = 0;
  cfsr_bus_t bus = '0;
  cfsr_flow_t flow = '0;
  cfsr_events_t evt = '0;
  logic [7:0] mrd = 8'h00, rdata, mwd, flg, r, d;
  logic [12:0] pc, epc, stk [8];
  logic [5:0] trim, codes [4];
  logic [8:0] madr;
  logic mwr, mrdo;
  logic [10:0] t;
  logic [2:0] sp = 3'h0;
  int failures = 0, comparisons = 0, cyc = 0;
  int unsigned pos [4];

  cfsr_core DUT (.mclk_i(mclk_i), .rstn_i(rstn_i), .por_i(por_i), .bod_i(bod_i),
    .bus_i(bus), .flow_i(flow), .evt_i(evt), .mem_rdata_i(mrd), .rdata_o(rdata),
    .pc_o(pc), .trim_code_o(trim), .peripheral_irq_flags_o(flg), .mem_addr_o(madr),
    .mem_wdata_o(mwd), .mem_wr_o(mwr), .mem_rd_o(mrdo));

  initial forever #12.5 mclk_i = ~mclk_i;

  // The whole sequence needs about 150 cycles; the ceiling leaves ample slack.
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge mclk_i);
    bus <= '{a, v, 1'b1, 1'b0};
    @(posedge mclk_i);
    bus <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk_i);
    bus <= '0;
    #1 chk(rdata, e);
  endtask : rd

  task automatic fl(input cfsr_op_t op, input logic [10:0] tg);
    @(posedge mclk_i);
    flow <= '{op, tg};
    @(posedge mclk_i);
    flow <= '0;
    #1;
  endtask : fl

  initial begin
    void'($urandom(32'h6e92));
    mrd = $urandom;
    pos = '{FLAG_TMR1, FLAG_CMP, FLAG_ADC, FLAG_NVM};
    codes = '{6'h3F, 6'h20, 6'h00, 6'h15};
    codes[3] = $urandom;
    repeat (3) @(posedge mclk_i);
    rstn_i <= 1'b1;
    #1 chk(pc, 0);
    rd(ADDR_FLAGS, FLAGS_RST);
    rd(ADDR_CAUSE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      evt <= cfsr_events_t'(4'h1 << i);
      @(posedge mclk_i);
      evt <= '0;
      #1 chk(flg, 20'h1 << pos[i]);
      repeat (3) @(posedge mclk_i);
      #1 chk(flg, 20'h1 << pos[i]);
      wr(ADDR_FLAGS, 8'h00);
      chk(flg, 0);
    end
    r = $urandom;
    wr(ADDR_FLAGS, r);
    chk(flg, r & FLAGS_MASK);
    // Corner case: an event in the same cycle as a software clear must win.
    @(posedge mclk_i);
    bus <= '{ADDR_FLAGS, 8'h00, 1'b1, 1'b0};
    evt <= cfsr_events_t'(4'h8);
    @(posedge mclk_i);
    bus <= '0;
    evt <= '0;
    #1 chk(flg, 8'h80);
    wr(ADDR_FLAGS, 8'h00);
    wr(ADDR_CAUSE, 8'hFF);
    rd(ADDR_CAUSE, 8'h03);
    @(posedge mclk_i);
    por_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    por_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd(ADDR_CAUSE, 8'h01);
    wr(ADDR_CAUSE, 8'hFF);
    @(posedge mclk_i);
    bod_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    bod_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    rd(ADDR_CAUSE, 8'h02);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_TRIM, {codes[i], 2'b11});
      chk(trim, codes[i]);
      rd(ADDR_TRIM, {codes[i], 2'b00});
    end
    r = $urandom;
    d = $urandom;
    wr(ADDR_LATCH, r);
    wr(ADDR_PCL, d);
    chk(pc, {r[4:0], d});
    rd(ADDR_PCL, d);
    t = $urandom;
    stk[sp] = {r[4:0], d} + 13'h1;
    sp++;
    fl(CFSR_OP_CALL, t);
    epc = {r[4:3], t};
    chk(pc, epc);
    t = $urandom;
    fl(CFSR_OP_JUMP, t);
    epc = {r[4:3], t};
    chk(pc, epc);
    // Clearing the upper latch bits keeps the call and interrupt targets unambiguous.
    r = r & 8'h07;
    wr(ADDR_LATCH, r);
    fl(CFSR_OP_STEP, 11'h000);
    epc++;
    chk(pc, epc);
    for (int i = 0; i < 9; i++) begin
      t = $urandom;
      stk[sp] = epc + 13'h1;
      sp++;
      fl(i == 4 ? CFSR_OP_IRQ : CFSR_OP_CALL, t);
      epc = {2'b00, t};
      chk(pc, epc);
    end
    for (int i = 0; i < 8; i++) begin
      sp--;
      fl(CFSR_OP_RET, 11'h000);
      chk(pc, stk[sp]);
    end
    rd(ADDR_LATCH, r);
    wr(ADDR_STATUS, 8'h00);
    r = 8'h20 + ($urandom & 8'h3F);
    wr(ADDR_POINTER, r);
    wr(ADDR_INDIRECT, d);
    chk({mwr, madr}, {2'b10, r});
    chk(mwd, d);
    rd(ADDR_INDIRECT, mrd);
    wr(ADDR_POINTER, 8'h00);
    rd(ADDR_INDIRECT, 8'h00);
    wr(ADDR_INDIRECT, d);
    chk(mwr, 0);
    @(posedge mclk_i);
    rstn_i <= 1'b0;
    @(posedge mclk_i);
    #1 chk(pc, 0);
    rstn_i <= 1'b1;
    rd(9'h030, mrd);
    wrap_up();
  end
endmodule : cfsr_core_bench
